// ===== hw/pm_channel_params.svh
// constants for the power manager command channel
// assumes inclusion by the channel package and module only
// Overview of operation
// - inbound bit 31 shows last emulation flag
// - inbound bits 7:4 hold last power state
// - command write clears empty, raises request
// - command bit 31 emulation, bits 7:4 state
// - coprocessor selects: c15,c14, opcode2 0 or 1
// - request held until manager acknowledges command
// - completed handshake sets transmit-empty again
// - inbound read clears full, acknowledges manager unless a query is in flight
// - reset sets transmit-empty and inbound-full
// - request carries four state bits, acknowledge answers
`ifndef PM_CHANNEL_PARAMS_SVH
`define PM_CHANNEL_PARAMS_SVH
`define PM_CRN          4'hf
`define PM_CRM          4'he
`define PM_OP2_STATUS   3'h0
`define PM_OP2_DATA     3'h1
`define PM_EMUL_BIT     31
`define PM_STATE_HI     7
`define PM_STATE_LO     4
`define PM_FLAG_W       1
`define PM_FLAG_R       0
`define PM_VER_HI       31
`define PM_VER_LO       28
`define PM_VERSION      4'h1
`endif

// ===== hw/pm_channel_pkg.sv
// types for the power manager command channel
// assumes the constants header sits beside it
`include "pm_channel_params.svh"
package pm_channel_pkg;
    typedef logic [3:0] power_state_type;   // nine-state encoding field
    typedef enum logic [1:0] {TX_IDLE, TX_REQ, TX_DROP} tx_phase_type;
    typedef enum logic [1:0] {RX_IDLE, RX_REQ, RX_DROP} rx_phase_type;
endpackage : pm_channel_pkg

// ===== hw/power_manager_command_channel.sv
// processor-side command channel to an external power manager
// assumes coprocessor transfers arrive as one-cycle strobes on sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "pm_channel_params.svh"
module power_manager_command_channel (
    input  wire logic                          sys_clk,        // 10 MHz clock
    input  wire logic                          rst,            // hard reset, sync high
    input  wire logic                          soft_reset_n,   // soft reset, sync low
    input  wire logic                          cpRead,         // coprocessor read strobe
    input  wire logic                          cpWrite,        // coprocessor write strobe
    input  wire logic [3:0]                    cpCrn,          // primary register select
    input  wire logic [3:0]                    cpCrm,          // secondary register select
    input  wire logic [2:0]                    cpOpcode2,      // opcode2 select
    input  wire logic [31:0]                   cpWriteData,    // write data
    output var  logic [31:0]                   cpReadData,     // registered read data
    output var  logic                          command_request,      // to manager
    output var  pm_channel_pkg::power_state_type command_state_bits, // to manager
    output var  logic                          commandEmulation,     // to manager
    input  wire logic                          command_acknowledge,  // from manager
    output var  logic                          state_query_request,  // to manager
    input  wire logic                          state_query_acknowledge, // from manager
    input  wire pm_channel_pkg::power_state_type previousState,      // from manager
    input  wire logic                          previousEmulation     // from manager
);
    import pm_channel_pkg::*;

    // how the channel behaves as a whole:
    // - the transmit side holds one command word (four state bits plus the
    //   emulation bit) and offers it to the manager with a level request
    // - the request and its data stand still until the acknowledge is seen,
    //   then the request falls and the channel waits for the acknowledge to
    //   fall too before the transmit-empty flag comes back
    // - the receive side fetches the previous state once after every reset,
    //   and again after each inbound read, so that the manager learns that
    //   the last word was taken
    // - the receive-full flag is set by reset before the previous state has
    //   arrived; software that polls it straight after reset may read the
    //   reset value of the inbound word, a known limitation of this scheme
    // - a read landing while a query is still in flight does not start a
    //   second query; keeping a pending bit was traded for a simpler machine
    // - both resets restart the channel, only the hard reset clears the
    //   read data register so a soft reset keeps the last answer visible
    // - writes to the status or inbound register have no defined effect
    //   and are dropped without touching any state

    // decoded coprocessor selects
    logic hitReg;
    logic statusRead;
    logic dataRead;
    logic dataWrite;
    logic anyReset;      // either reset restarts the channel

    assign hitReg     = (cpCrn == `PM_CRN) && (cpCrm == `PM_CRM);
    assign statusRead = cpRead && hitReg && (cpOpcode2 == `PM_OP2_STATUS);
    assign dataRead   = cpRead && hitReg && (cpOpcode2 == `PM_OP2_DATA);
    // writes to status or inbound register are ignored, no defined effect
    assign dataWrite  = cpWrite && hitReg && (cpOpcode2 == `PM_OP2_DATA);
    assign anyReset   = rst || !soft_reset_n;

    // transmit channel state
    tx_phase_type    txPhase;
    tx_phase_type    next_txPhase;
    logic            txEmpty;          // W flag
    logic            next_txEmpty;
    power_state_type next_commandState;
    logic            next_commandEmul;
    logic            next_commandRequest;

    // transmit next-state: hold request with data until acknowledged,
    // then wait for the acknowledge to drop before reopening the channel
    always_comb begin
        next_txPhase        = txPhase;
        next_txEmpty        = txEmpty;
        next_commandState   = command_state_bits;
        next_commandEmul    = commandEmulation;
        next_commandRequest = command_request;
        case (txPhase)
            TX_IDLE: begin
                // a write while busy is undefined; it is simply dropped here
                if (dataWrite && txEmpty) begin
                    next_txEmpty        = 1'b0;
                    next_commandState   = cpWriteData[`PM_STATE_HI:`PM_STATE_LO];
                    next_commandEmul    = cpWriteData[`PM_EMUL_BIT];
                    next_commandRequest = 1'b1;
                    next_txPhase        = TX_REQ;
                end
            end
            TX_REQ: begin
                if (command_acknowledge) begin
                    next_commandRequest = 1'b0;
                    next_txPhase        = TX_DROP;
                end
            end
            TX_DROP: begin
                // double-ended: empty only once acknowledge is released
                if (!command_acknowledge) begin
                    next_txEmpty = 1'b1;
                    next_txPhase = TX_IDLE;
                end
            end
            default: begin
                next_txPhase = TX_IDLE;
            end
        endcase
    end

    // transmit registers
    always_ff @(posedge sys_clk) begin
        if (anyReset) begin
            txPhase            <= TX_IDLE;
            txEmpty            <= 1'b1;
            command_state_bits <= 4'h0;
            commandEmulation   <= 1'b0;
            command_request    <= 1'b0;
        end else begin
            txPhase            <= next_txPhase;
            txEmpty            <= next_txEmpty;
            command_state_bits <= next_commandState;
            commandEmulation   <= next_commandEmul;
            command_request    <= next_commandRequest;
        end
    end

    // receive channel state
    rx_phase_type    rxPhase;
    rx_phase_type    next_rxPhase;
    logic            rxFull;           // R flag
    logic            next_rxFull;
    power_state_type inState;          // last programmed power state
    power_state_type next_inState;
    logic            inEmul;           // last emulation flag
    logic            next_inEmul;
    logic            next_queryRequest;

    // receive next-state: after reset the previous state is fetched once;
    // a read of the inbound register with no query in flight tells the manager it was accepted
    always_comb begin
        next_rxPhase      = rxPhase;
        next_rxFull       = rxFull;
        next_inState      = inState;
        next_inEmul       = inEmul;
        next_queryRequest = state_query_request;
        // read acknowledge clears full; a capture in the same cycle still wins
        if (dataRead) begin
            next_rxFull = 1'b0;
        end
        case (rxPhase)
            RX_REQ: begin
                if (state_query_acknowledge) begin
                    next_inState      = previousState;
                    next_inEmul       = previousEmulation;
                    next_rxFull       = 1'b1;
                    next_queryRequest = 1'b0;
                    next_rxPhase      = RX_DROP;
                end
            end
            RX_DROP: begin
                if (!state_query_acknowledge) begin
                    next_rxPhase = RX_IDLE;
                end
            end
            RX_IDLE: begin
                // after a read, ask again so the manager sees the acceptance
                if (dataRead) begin
                    next_queryRequest = 1'b1;
                    next_rxPhase      = RX_REQ;
                end
            end
            default: begin
                next_rxPhase = RX_IDLE;
            end
        endcase
    end

    // receive registers; reset launches the previous-state query
    always_ff @(posedge sys_clk) begin
        if (anyReset) begin
            rxPhase             <= RX_REQ;
            rxFull              <= 1'b1;
            inState             <= 4'h0;
            inEmul              <= 1'b0;
            state_query_request <= 1'b1;
        end else begin
            rxPhase             <= next_rxPhase;
            rxFull              <= next_rxFull;
            inState             <= next_inState;
            inEmul              <= next_inEmul;
            state_query_request <= next_queryRequest;
        end
    end

    // read data mux: status shows flags and version, inbound shows state
    logic [31:0] next_readData;
    always_comb begin
        next_readData = 32'h0;
        if (statusRead) begin
            next_readData[`PM_VER_HI:`PM_VER_LO] = `PM_VERSION;
            next_readData[`PM_FLAG_W]            = txEmpty;
            next_readData[`PM_FLAG_R]            = rxFull;
        end else if (dataRead) begin
            next_readData[`PM_EMUL_BIT]                 = inEmul;
            next_readData[`PM_STATE_HI:`PM_STATE_LO]    = inState;
        end
    end

    // read data register; holds the last answer until the next read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cpReadData <= 32'h0;
        end else if (cpRead) begin
            cpReadData <= next_readData;
        end
    end
endmodule : power_manager_command_channel
`default_nettype wire

// ===== sim/pm_channel_chk.sv
// assertions on the command channel ports
// assumes it is bound onto the channel top module
`timescale 1ns/1ps
`default_nettype none
module pm_channel_chk (
    input wire logic                            sys_clk,
    input wire logic                            rst,
    input wire logic                            soft_reset_n,
    input wire logic                            cpRead,
    input wire logic                            cpWrite,
    input wire logic [3:0]                      cpCrn,
    input wire logic [3:0]                      cpCrm,
    input wire logic [2:0]                      cpOpcode2,
    input wire logic [31:0]                     cpWriteData,
    input wire logic [31:0]                     cpReadData,
    input wire logic                            command_request,
    input wire pm_channel_pkg::power_state_type command_state_bits,
    input wire logic                            commandEmulation,
    input wire logic                            command_acknowledge,
    input wire logic                            state_query_request,
    input wire logic                            state_query_acknowledge,
    input wire pm_channel_pkg::power_state_type previousState,
    input wire logic                            previousEmulation
);
    // decoded register strobes
    wire logic wr = cpWrite && cpCrn == 4'hf && cpCrm == 4'he && cpOpcode2 == 3'h1;
    wire logic rd = cpRead && cpCrn == 4'hf && cpCrm == 4'he && cpOpcode2 == 3'h1;
    wire logic st = cpRead && cpCrn == 4'hf && cpCrm == 4'he && cpOpcode2 == 3'h0;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst || !soft_reset_n);
    // transmit channel idle long enough for the empty flag to be back
    sequence sFree; !command_request && !command_acknowledge && !$past(command_acknowledge); endsequence
    // data read, a gap, then a status read, manager quiet all along
    sequence sReadGap; (rd && !state_query_acknowledge) ##1 !state_query_acknowledge ##1 (st && !state_query_acknowledge); endsequence
    AST_TX_START: assert property (sFree ##0 wr |=> command_request && command_state_bits == $past(cpWriteData[7:4])
        && commandEmulation == $past(cpWriteData[31])) else $error("command not launched from write");
    AST_TX_HOLD: assert property (command_request && !command_acknowledge |=> command_request
        && $stable(command_state_bits) && $stable(commandEmulation)) else $error("request not held");
    AST_TX_DROP: assert property (command_request && command_acknowledge |=> !command_request)
        else $error("request kept after acknowledge");
    AST_W_BUSY: assert property (st && command_request |=> !cpReadData[1])
        else $error("empty flag set while busy");
    AST_W_BACK: assert property (sFree ##0 st |=> cpReadData[1])
        else $error("empty flag not restored");
    AST_STATUS_FIXED: assert property (st |=> cpReadData[31:28] == 4'h1 && cpReadData[27:2] == 26'h0)
        else $error("status fixed fields wrong");
    AST_RX_REQUERY: assert property (rd |=> state_query_request)
        else $error("read not acknowledged");
    AST_RX_CLEAR: assert property (sReadGap |=> !cpReadData[0])
        else $error("full flag not cleared");
endmodule : pm_channel_chk
bind power_manager_command_channel pm_channel_chk i_chk (.sys_clk, .rst, .soft_reset_n, .cpRead,
    .cpWrite, .cpCrn, .cpCrm, .cpOpcode2, .cpWriteData, .cpReadData, .command_request,
    .command_state_bits, .commandEmulation, .command_acknowledge, .state_query_request,
    .state_query_acknowledge, .previousState, .previousEmulation);
`default_nettype wire

// ===== sim/pm_manager_model.sv
// behavioural power manager answering both handshakes
// assumes direct wiring to the channel pins
`timescale 1ns/1ps
`default_nettype none
module pm_manager_model (
    input  wire logic       sys_clk,
    input  wire logic       command_request,
    output var  logic       command_acknowledge,
    input  wire logic       state_query_request,
    output var  logic       state_query_acknowledge,
    output wire logic [4:0] lastOut,   // {emulation, state}
    input  wire logic [4:0] lastWord,  // previous state to report
    input  wire logic [3:0] lag        // cycles before each acknowledge
);
    // data only valid beside the acknowledge, inverted otherwise
    assign lastOut = state_query_acknowledge ? lastWord : ~lastWord;
    initial {command_acknowledge, state_query_acknowledge} = 2'b00;
    // supply handling is out of scope: no regulator is modelled, so no
    // command can lower it
    // ack after lag, dropped once the request falls
    always begin
        @(posedge sys_clk iff command_request);
        repeat (lag) @(posedge sys_clk);
        #1 command_acknowledge = 1'b1;
        @(posedge sys_clk iff !command_request);
        #1 command_acknowledge = 1'b0;
    end
    // previous-state answer follows the same pattern
    always begin
        @(posedge sys_clk iff state_query_request);
        repeat (lag) @(posedge sys_clk);
        #1 state_query_acknowledge = 1'b1;
        @(posedge sys_clk iff !state_query_request);
        #1 state_query_acknowledge = 1'b0;
    end
endmodule : pm_manager_model
`default_nettype wire

// ===== sim/tb_power_manager_command_channel.sv
// self-checking bench for the power manager command channel
// assumes checker, manager model and design compile before it
`timescale 1ns/1ps
`default_nettype none
module tb_power_manager_command_channel;
    import pm_channel_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, soft_reset_n = 1'b1, cpRead = 1'b0, cpWrite = 1'b0;
    logic [3:0]  cpCrn = 4'hf, cpCrm = 4'he, lag = 4'h3;
    logic [2:0]  cpOpcode2 = 3'h0;
    logic [4:0]  lastWord = 5'h1a;
    logic [31:0] cpWriteData = 32'h0, got;
    wire logic [31:0] cpReadData;
    wire logic [4:0]  lastOut;
    wire logic command_request, commandEmulation, command_acknowledge;
    wire logic state_query_request, state_query_acknowledge;
    wire power_state_type command_state_bits;
    int fails = 0, compares = 0, cycles = 0;
    power_manager_command_channel i_dut (.sys_clk, .rst, .soft_reset_n, .cpRead, .cpWrite,
        .cpCrn, .cpCrm, .cpOpcode2, .cpWriteData, .cpReadData, .command_request,
        .command_state_bits, .commandEmulation, .command_acknowledge, .state_query_request,
        .state_query_acknowledge, .previousState(lastOut[3:0]), .previousEmulation(lastOut[4]));
    pm_manager_model i_mgr (.sys_clk, .command_request, .command_acknowledge,
        .state_query_request, .state_query_acknowledge, .lastOut, .lastWord, .lag);
    initial forever #50 sys_clk = ~sys_clk;
    // cut a hang short
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            wrap_up;
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one coprocessor transfer; a spare edge first so strobes never toggle twice at once
    task automatic acc(input logic wr, input logic [2:0] op2, input logic [31:0] d);
        @(posedge sys_clk);
        #1;
        cpOpcode2 = op2;
        cpWriteData = d;
        cpWrite = wr;
        cpRead = !wr;
        @(posedge sys_clk);
        #1;
        got = cpReadData;
        cpWrite = 1'b0;
        cpRead = 1'b0;
    endtask : acc
    // poll a status flag, bounded
    task automatic poll(input int b);
        for (int i = 0; i < 40; i++) begin
            acc(1'b0, 3'h0, 32'h0);
            if (got[b] === 1'b1) break;
        end
    endtask : poll
    task automatic t_reset;
        acc(1'b0, 3'h0, 32'h0);
        chk("status after reset", got, 32'h1000_0003);
        for (int i = 0; i < 20 && state_query_request; i++) @(posedge sys_clk);
        poll(0);
        acc(1'b0, 3'h1, 32'h0); // inbound only read
        chk("previous state", got, 32'h8000_00a0);
        acc(1'b0, 3'h0, 32'h0);
        chk("status after read", got, 32'h1000_0002);
        chk("query raised", {31'h0, state_query_request}, 32'h1);
        $display("reset test done");
    endtask : t_reset
    task automatic t_send;
        power_state_type codes[9] = '{4'hf, 4'he, 4'hc, 4'h8, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
        foreach (codes[i]) begin
            lag = i[3:0]; // prompt and slow manager
            poll(1);
            chk("transmit empty", {31'h0, got[1]}, 32'h1);
            acc(1'b1, 3'h1, {i[0], 23'h0, codes[i], 4'h0});
            chk("command pins", {26'h0, command_request, commandEmulation, command_state_bits},
                {27'h1, i[0], codes[i]});
            acc(1'b0, 3'h0, 32'h0);
            chk("empty cleared", {31'h0, got[1]}, 32'h0);
        end
        $display("send test done");
    endtask : t_send
    task automatic t_refuse;
        lag = 4'h6;
        poll(1);
        acc(1'b1, 3'h1, 32'h8000_00d0);
        acc(1'b1, 3'h1, 32'h0000_0020);
        chk("busy write ignored", {27'h0, commandEmulation, command_state_bits}, 32'h1d);
        cpCrm = 4'hd;
        acc(1'b0, 3'h1, 32'h0);
        cpCrm = 4'he;
        chk("unmapped read", got, 32'h0);
        $display("refuse test done");
    endtask : t_refuse
    task automatic t_soft;
        lag = 4'h8;
        lastWord = 5'h05;
        poll(1);
        acc(1'b1, 3'h1, 32'h0000_0040); // nap, no emulation
        // external soft reset stands in for the manager's own
        soft_reset_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("request in soft reset", {31'h0, command_request}, 32'h0);
        soft_reset_n = 1'b1;
        acc(1'b0, 3'h0, 32'h0);
        chk("status after soft reset", got, 32'h1000_0003);
        for (int i = 0; i < 20 && state_query_request; i++) @(posedge sys_clk);
        acc(1'b0, 3'h1, 32'h0);
        chk("state after soft reset", got, 32'h0000_0050);
        chk("previous state class", {30'h0, got[7:6]}, 32'h1);
        $display("soft reset test done");
    endtask : t_soft
    task automatic wrap_up;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (12) @(posedge sys_clk);
        #1 rst = 1'b0;
        t_reset;
        t_send;
        t_refuse;
        t_soft;
        wrap_up;
    end
endmodule : tb_power_manager_command_channel
`default_nettype wire
